// [rtl/loader_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types of the strap and serial init loader
// Assumes: 25 MHz core clock; ROM link at standard rate
// Notes:   Strap bit positions follow the local address/data bus
//////////////////////////////////////////////////////////////////////////////
package loader_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int I2C_QTR_NS    = 2500;
	// Least quarter-bit time, rounded up to whole cycles
	localparam int QTR_CYC       = (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [1:0]  CAP_WAIT          = 2'h2;
	localparam logic [31:0] LAST_ITEM_DEFAULT = 32'hffff_ffff;
	localparam logic [31:0] ROM_MODE_KEEP     = 32'hf000_001e;
	localparam logic [31:0] STRAP_DEFAULTS    = 32'h0181_8d2c;
	localparam logic [4:0]  ROM_ADDR_BASE     = 5'h14;
	localparam logic [31:0] GPP_INIT_MASK     = 32'h0400_0000;
	localparam logic [1:0]  BOOTW_32          = 2'h2;
	localparam logic [3:0]  ACK_BIT           = 4'h8;
	localparam logic [2:0]  LAST_BYTE         = 3'h7;

	localparam int B_ROM_EN   = 0;
	localparam int B_OFF_W    = 1;
	localparam int B_DEV_LO   = 2;
	localparam int B_ENDIAN   = 4;
	localparam int B_SYNC     = 5;
	localparam int B_BUSMODE  = 6;
	localparam int B_ARB      = 8;
	localparam int B_MULTI    = 9;
	localparam int B_ID_LO    = 10;
	localparam int B_UMA      = 12;
	localparam int B_UMA_TYPE = 13;
	localparam int B_BOOTW_LO = 14;
	localparam int B_RETRY    = 16;
	localparam int B_FBCLK    = 23;
	localparam int B_BASE     = 24;
	localparam int B_PLL_TUNE = 28;
	localparam int B_PLL_DIV  = 29;
	localparam int B_PLL_BYP  = 30;
	localparam int B_VOLT     = 31;

	typedef struct packed {
		logic       rom_load_en;
		logic       wide_offset;
		logic [6:0] rom_dev_addr;
		logic       big_endian;
		logic       cpu_if_sync;
		logic       bus_extended;
		logic       arbiter_en;
		logic       multi_ctrl_en;
		logic [1:0] addr_id;
		logic       unified_memory_mode;
		logic       uma_slave;
		logic       boot_cs_width32;
		logic       pci_retry_en;
		logic       sdram_fb_clock_sel;
		logic       regs_at_default_base;
		logic       pll_tune_opt;
		logic       pll_div_opt;
		logic       pll_bypass;
		logic       cpu_if_volt_alt;
	} strap_modes_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} wr_rec_t;

	typedef enum {ST_CAPTURE, ST_START, ST_TX, ST_RX, ST_PUSH, ST_STOP, ST_DONE} state_t;
	typedef enum {SQ_ADDR_W, SQ_OFF_HI, SQ_OFF_LO, SQ_ADDR_R, SQ_READ} seq_t;
endpackage : loader_pkg

// [rtl/rec_buffer.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Small valid/ready buffer for decoded write records
// Assumes: DEPTH is a power of two
// Notes:   Full and empty are exact; no bypass path
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module rec_buffer #(
	parameter int W     = 64,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = cnt_reg != (AW + 1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data  = mem[rp_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : rec_buffer

// [rtl/strap_init_loader.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Captures power-up straps and runs the optional serial ROM init
// Assumes: Straps stable at reset release; ROM answers as a plain 2-wire slave
// Notes:   Processor reset is held until every record has left the buffer
//////////////////////////////////////////////////////////////////////////////
// Function
// - Jumper picks strap-only start or straps plus serial ROM loading
// - Strap-only mode latches the whole bus at reset release
// - Each 8-byte record writes its 32-bit data to its 32-bit address
// - Loading stops when the data item equals the last-item pattern
// - Processor stays in reset until ROM loading has finished
// - ROM mode still samples offset width, ROM address, endian, PLL, voltage
// - Strap bit 0 low skips ROM loading, high performs it
// - Bit 1 low gives one offset byte; bits 3:2 complete ROM address
// - Bits 5, 8, 16 set sync interface, arbiter, PCI retry
// - Bits 15:14 at 10 give a 32-bit boot chip-select device
// - Bit 24 high puts register space at its default base
// - Decode multi-controller, address id, unified memory, feedback clock
// - All general-purpose pins but pin 26 come up as inputs
// - General-purpose pin 26 drives the init-in-progress flag
`timescale 1ns/1ns
module strap_init_loader #(
	parameter logic [31:0] LAST_ITEM = loader_pkg::LAST_ITEM_DEFAULT
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic [31:0]              ad_in,
	input  wire logic                     scl_in,
	output logic                          scl_out,
	output logic                          scl_oe,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	output loader_pkg::wr_rec_t           wr_rec,
	output logic                          wr_valid,
	input  wire logic                     wr_ready,
	output loader_pkg::strap_modes_t      modes,
	output logic                          modes_valid,
	output logic                          nack_error,
	output logic                          init_in_progress_out,
	output logic                          cpu_reset_n_out,
	output logic [31:0]                   general_purpose_port_out,
	output logic [31:0]                   general_purpose_port_oe
);
	import loader_pkg::*;

	localparam int DIV_W = $clog2(QTR_CYC);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [31:0] ad_m_reg;
	logic [31:0] ad_s_reg;
	logic        scl_m_reg;
	logic        scl_s_reg;
	logic        sda_m_reg;
	logic        sda_s_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ad_m_reg  <= '0;
			ad_s_reg  <= '0;
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			ad_m_reg  <= ad_in;
			ad_s_reg  <= ad_m_reg;
			scl_m_reg <= scl_in;
			scl_s_reg <= scl_m_reg;
			sda_m_reg <= sda_in;
			sda_s_reg <= sda_m_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strap decode
	state_t       state_reg;
	seq_t         seq_reg;
	logic [1:0]   cap_cnt_reg;
	strap_modes_t modes_reg;
	strap_modes_t modes_next;
	logic [31:0]  cap_word;

	wire cap_go = state_reg == ST_CAPTURE && cap_cnt_reg == CAP_WAIT;
	// Unsampled straps take their STRAP_DEFAULTS values in ROM mode
	assign cap_word = ad_s_reg[B_ROM_EN] ?
		((ad_s_reg & ROM_MODE_KEEP) | (STRAP_DEFAULTS & ~ROM_MODE_KEEP) |
		(32'h0000_0001 << B_ROM_EN)) : ad_s_reg;

	assign modes_next.rom_load_en  = cap_word[B_ROM_EN];
	assign modes_next.wide_offset  = cap_word[B_OFF_W];
	assign modes_next.rom_dev_addr = {ROM_ADDR_BASE, cap_word[B_DEV_LO+1:B_DEV_LO]};
	assign modes_next.big_endian   = cap_word[B_ENDIAN];
	assign modes_next.cpu_if_sync  = cap_word[B_SYNC];
	assign modes_next.bus_extended = cap_word[B_BUSMODE];
	assign modes_next.arbiter_en   = cap_word[B_ARB];
	assign modes_next.multi_ctrl_en = cap_word[B_MULTI];
	assign modes_next.addr_id      = cap_word[B_ID_LO+1:B_ID_LO];
	assign modes_next.unified_memory_mode = cap_word[B_UMA];
	assign modes_next.uma_slave    = cap_word[B_UMA_TYPE];
	assign modes_next.boot_cs_width32 =
		cap_word[B_BOOTW_LO+1:B_BOOTW_LO] == BOOTW_32;
	assign modes_next.pci_retry_en = cap_word[B_RETRY];
	assign modes_next.sdram_fb_clock_sel = cap_word[B_FBCLK];
	assign modes_next.regs_at_default_base = cap_word[B_BASE];
	assign modes_next.pll_tune_opt = cap_word[B_PLL_TUNE];
	assign modes_next.pll_div_opt  = cap_word[B_PLL_DIV];
	assign modes_next.pll_bypass   = cap_word[B_PLL_BYP];
	assign modes_next.cpu_if_volt_alt = cap_word[B_VOLT];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cap_cnt_reg <= '0;
			modes_reg   <= '0;
			modes_valid <= 1'b0;
		end else if (state_reg == ST_CAPTURE) begin
			cap_cnt_reg <= cap_cnt_reg + 1'b1;
			if (cap_go) begin
				modes_reg   <= modes_next;
				modes_valid <= 1'b1;
			end
		end
	end
	assign modes = modes_reg;

	////////////////////////////////////////////////////////////////////////
	// Bit timing
	logic [DIV_W-1:0] div_reg;
	logic [1:0]       ph_reg;
	logic [3:0]       bit_reg;
	logic [2:0]       byte_reg;
	logic [7:0]       shift_reg;
	logic [63:0]      rec_reg;
	logic             nak_reg;

	wire tick    = div_reg == DIV_W'(QTR_CYC - 1);
	// Hold the phase while a slave stretches the clock low
	wire adv     = tick && !(ph_reg == 2'h1 && !scl_s_reg);
	wire bit_end = adv && ph_reg == 2'h3;
	wire at_ack  = bit_reg == ACK_BIT;
	wire match   = byte_reg == LAST_BYTE && rec_reg[31:0] == LAST_ITEM;
	wire in_bits = state_reg == ST_START || state_reg == ST_TX || state_reg == ST_RX;
	wire scl_low_w = (in_bits && (ph_reg == 2'h0 || ph_reg == 2'h3)) ||
		(state_reg == ST_STOP && ph_reg == 2'h0) || state_reg == ST_PUSH;
	wire sda_low_w = (state_reg == ST_START && ph_reg[1]) ||
		(state_reg == ST_TX && !at_ack && !shift_reg[7]) ||
		(state_reg == ST_RX && at_ack && !match) ||
		(state_reg == ST_STOP && !ph_reg[1]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= '0;
		end else begin
			div_reg <= tick ? '0 : div_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	logic push_rdy;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= ST_CAPTURE;
			seq_reg    <= SQ_ADDR_W;
			nack_error <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_CAPTURE: begin
					if (cap_go) begin
						state_reg <= cap_word[B_ROM_EN] ? ST_START : ST_DONE;
					end
				end
				ST_START: begin
					if (bit_end) begin
						state_reg <= ST_TX;
					end
				end
				ST_TX: begin
					if (bit_end && at_ack) begin
						if (nak_reg) begin
							state_reg  <= ST_STOP;
							nack_error <= 1'b1;
						end else begin
							unique case (seq_reg)
								SQ_ADDR_W: seq_reg <= modes_reg.wide_offset ?
									SQ_OFF_HI : SQ_OFF_LO;
								SQ_OFF_HI: seq_reg <= SQ_OFF_LO;
								SQ_OFF_LO: begin
									seq_reg   <= SQ_ADDR_R;
									state_reg <= ST_START;
								end
								SQ_ADDR_R: begin
									seq_reg   <= SQ_READ;
									state_reg <= ST_RX;
								end
								SQ_READ: state_reg <= ST_RX;
							endcase
						end
					end
				end
				ST_RX: begin
					if (bit_end && at_ack && byte_reg == LAST_BYTE) begin
						state_reg <= match ? ST_STOP : ST_PUSH;
					end
				end
				ST_PUSH: begin
					if (push_rdy) begin
						state_reg <= ST_RX;
					end
				end
				ST_STOP: begin
					if (bit_end) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_reg <= ST_DONE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_reg   <= '0;
			bit_reg  <= '0;
			byte_reg <= '0;
		end else if (state_reg == ST_PUSH || bit_end && state_reg == ST_START) begin
			ph_reg   <= '0;
			bit_reg  <= '0;
			byte_reg <= '0;
		end else if (adv && (in_bits || state_reg == ST_STOP)) begin
			ph_reg <= ph_reg + 1'b1;
			if (bit_end) begin
				bit_reg  <= at_ack ? '0 : bit_reg + 1'b1;
				byte_reg <= (state_reg == ST_RX && at_ack) ? byte_reg + 1'b1 : byte_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_reg <= '0;
			rec_reg   <= '0;
			nak_reg   <= 1'b0;
		end else if (state_reg == ST_START) begin
			shift_reg <= {modes_reg.rom_dev_addr, seq_reg == SQ_ADDR_R};
		end else if (state_reg == ST_TX && bit_end) begin
			// Offsets shift in zeros: reading starts at byte zero
			shift_reg <= at_ack ? 8'h00 : {shift_reg[6:0], 1'b0};
		end else if (adv && ph_reg == 2'h2) begin
			if (state_reg == ST_TX && at_ack) begin
				nak_reg <= sda_s_reg;
			end
			if (state_reg == ST_RX && !at_ack) begin
				rec_reg <= {rec_reg[62:0], sda_s_reg};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Record buffer and outputs
	wr_rec_t buf_out;
	wire     push_vld = state_reg == ST_PUSH;

	rec_buffer #(.W($bits(wr_rec_t)), .DEPTH(2)) u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (push_vld),
		.in_ready  (push_rdy),
		.in_data   (rec_reg),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (buf_out)
	);
	assign wr_rec = buf_out;

	logic scl_oe_reg;
	logic sda_oe_reg;
	logic init_reg;
	logic cpu_rel_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_oe_reg  <= 1'b0;
			sda_oe_reg  <= 1'b0;
			init_reg    <= 1'b0;
			cpu_rel_reg <= 1'b0;
		end else begin
			scl_oe_reg  <= scl_low_w;
			sda_oe_reg  <= sda_low_w;
			// Queued writes still count as init work
			init_reg    <= state_reg != ST_CAPTURE &&
				!(state_reg == ST_DONE && !wr_valid);
			cpu_rel_reg <= state_reg == ST_DONE && !wr_valid;
		end
	end

	assign scl_oe  = scl_oe_reg;
	assign sda_oe  = sda_oe_reg;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign init_in_progress_out     = init_reg;
	assign cpu_reset_n_out          = cpu_rel_reg;
	assign general_purpose_port_out = init_reg ? GPP_INIT_MASK : '0;
	assign general_purpose_port_oe  = GPP_INIT_MASK;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_stop_done;
		state_reg == ST_STOP ##[1:1000] state_reg == ST_DONE;
	endsequence

	cpu_reset_hold_a: assert property (init_reg |-> !cpu_rel_reg)
		else $error("processor released during init");
	strap_skip_a: assert property (cap_go && !ad_s_reg[B_ROM_EN] |=> state_reg == ST_DONE)
		else $error("strap-only mode did not finish");
	rom_start_a: assert property (cap_go && ad_s_reg[B_ROM_EN] |=> state_reg == ST_START)
		else $error("ROM mode did not start loading");
	strap_latch_a: assert property (cap_go && !ad_s_reg[B_ROM_EN] |=> modes_reg.bus_extended == $past(ad_s_reg[B_BUSMODE]))
		else $error("bus protocol strap not latched");
	rom_defaults_a: assert property (cap_go && ad_s_reg[B_ROM_EN] |=> modes_reg.pci_retry_en && modes_reg.pll_bypass == $past(ad_s_reg[B_PLL_BYP]) && modes_reg.bus_extended == STRAP_DEFAULTS[B_BUSMODE])
		else $error("ROM mode strap sampling wrong");
	last_item_a: assert property (state_reg == ST_RX && bit_end && at_ack && match |=> state_reg == ST_STOP ##0 s_stop_done)
		else $error("last item did not end loading");
	push_data_a: assert property (push_vld && push_rdy |-> rec_reg[31:0] != LAST_ITEM ##1 state_reg == ST_RX)
		else $error("record push wrong");
	dev_addr_a: assert property (state_reg == ST_START && bit_end |=> shift_reg[7:1] == modes_reg.rom_dev_addr)
		else $error("ROM device address wrong");
	offset_zero_a: assert property (state_reg == ST_TX && (seq_reg == SQ_OFF_HI || seq_reg == SQ_OFF_LO) |-> shift_reg == 8'h00)
		else $error("ROM offset not zero");
	gpp_pin_a: assert property (general_purpose_port_out[26] == init_in_progress_out && general_purpose_port_oe == GPP_INIT_MASK)
		else $error("init pin not driven");
endmodule : strap_init_loader

// [tb/init_rom_model.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Behavioural serial init ROM on the open-drain 2-wire bus
// Assumes: Pull-ups on both wires; one offset byte
// Notes:   Stops sending after a controller NACK, like a real part
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module init_rom_model #(
	parameter logic [6:0] DEV = 7'h53
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_low
);
	logic [7:0] mem [0:255];
	logic [7:0] ptr;
	logic [7:0] sh;
	int         cnt;
	logic       act;
	logic       rd;
	logic       first;
	logic       skip;

	initial begin
		sda_low = 1'b0;
		act = 1'b0;
	end
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		first = 1'b1;
		rd = 1'b0;
		skip = 1'b1;
		cnt = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 1'b0;
	end
	always @(posedge scl) if (act) begin
		if (!rd && cnt < 8) begin
			sh = {sh[6:0], sda};
		end
		// Controller NACK ends the read
		if (rd && cnt == 8 && sda) begin
			act = 1'b0;
		end
	end
	always @(negedge scl) if (act) begin
		if (skip) begin
			skip = 1'b0;
		end else if (cnt == 8) begin
			first = 1'b0;
			cnt = 0;
			sh = mem[ptr];
			sda_low = rd && !sh[7];
			ptr = ptr + 8'(rd);
		end else if (cnt == 7 && !rd) begin
			if (first) begin
				act = (sh[7:1] == DEV);
				rd = sh[0];
			end else begin
				ptr = sh;
			end
			sda_low = act;
			cnt = 8;
		end else begin
			sda_low = rd && cnt < 7 && !sh[6 - cnt];
			cnt = cnt + 1;
		end
	end
endmodule : init_rom_model

// [tb/tb_top.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of strap capture and serial ROM loading
// Assumes: Bench ROM answers only at the strap-selected address
// Notes:   One ROM run covers stall, drain and end pattern to stay short
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module tb_top;
	import loader_pkg::*;
	logic         clk, nrst, wr_ready, sda_low, wr_valid, modes_valid, nack_error;
	logic         scl_out, scl_oe, sda_out, sda_oe, init_in_progress_out, cpu_reset_n_out;
	logic [31:0]  ad_in, general_purpose_port_out, general_purpose_port_oe;
	logic [63:0]  recs [0:3];
	wr_rec_t      wr_rec;
	strap_modes_t modes;
	int           n_errors, checks, i, k;
	wire          scl = !scl_oe;
	wire          sda = !(sda_oe || sda_low);

	strap_init_loader u_strap_init_loader (
		.clk(clk), .nrst(nrst), .ad_in(ad_in),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.wr_rec(wr_rec), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.modes(modes), .modes_valid(modes_valid), .nack_error(nack_error),
		.init_in_progress_out(init_in_progress_out), .cpu_reset_n_out(cpu_reset_n_out),
		.general_purpose_port_out(general_purpose_port_out),
		.general_purpose_port_oe(general_purpose_port_oe)
	);
	init_rom_model u_init_rom_model (.scl(scl), .sda(sda), .sda_low(sda_low));

	initial clk = 1'b0;
	always #20 clk = ~clk;

	//////////////////////////////////////////////////////////////////////////////
	function automatic strap_modes_t exp_modes(input logic [31:0] w);
		return '{w[0], w[1], {ROM_ADDR_BASE, w[3:2]}, w[4], w[5], w[6], w[8], w[9],
			w[11:10], w[12], w[13], w[15:14] == BOOTW_32, w[16], w[23], w[24],
			w[28], w[29], w[30], w[31]};
	endfunction : exp_modes

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic results;
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic timeout(input int lim, input string what);
		if (i >= lim) begin
			n_errors++;
			$display("[FAIL] %s expected done seen timeout", what);
			results();
		end
	endtask : timeout

	// Reset, capture, then move the pins to show the capture is kept
	task automatic start(input logic [31:0] ad);
		logic [31:0] keep;
		logic [31:0] eff;
		keep = ROM_MODE_KEEP | 32'h0000_0001;
		eff = ad[0] ? ((ad & keep) | (STRAP_DEFAULTS & ~keep)) : ad;
		@(posedge clk);
		nrst     <= 1'b0;
		ad_in    <= ad;
		wr_ready <= 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk("cpu_reset_n_out", 64'(0), 64'(cpu_reset_n_out));
		chk("modes_valid", 64'(0), 64'(modes_valid));
		chk("gpp_oe", 64'(GPP_INIT_MASK), 64'(general_purpose_port_oe));
		chk("pin drive levels", 64'(0), 64'({scl_out, sda_out}));
		@(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 8 && modes_valid !== 1'b1; i++)
			@(negedge clk);
		timeout(8, "modes_valid");
		chk("modes", 64'(exp_modes(eff)), 64'(modes));
		@(posedge clk);
		ad_in <= ~ad;
		repeat (4) @(negedge clk);
		chk("modes held", 64'(exp_modes(eff)), 64'(modes));
	endtask : start

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst     = 1'b0;
		ad_in    = 32'h0000_0000;
		wr_ready = 1'b0;
		n_errors = 0;
		checks   = 0;
		// Third record sits one bit off the end pattern
		recs = '{64'h1234_5678_9abc_def0, 64'hf100_0010_0000_0001,
			64'h0000_0000_ffff_fffe, 64'h5555_aaaa_ffff_ffff};
		for (k = 0; k < 32; k++)
			u_init_rom_model.mem[k] = recs[k / 8][63 - 8 * (k % 8) -: 8];
		for (k = 0; k < 2; k++) begin
			start(k ? 32'h7000_4242 : 32'h0181_8d2c);
			for (i = 0; i < 4 && cpu_reset_n_out !== 1'b1; i++)
				@(negedge clk);
			timeout(4, "cpu_reset_n_out");
			chk("init", 64'(0), 64'(init_in_progress_out));
			chk("gpp_out", 64'(0), 64'(general_purpose_port_out));
			chk("link idle", 64'(3), 64'({scl, sda}));
		end
		// Pins 6 and 9 high must not reach the modes in ROM mode
		start(32'h0000_024d);
		repeat (2) @(negedge clk);
		chk("init", 64'(1), 64'(init_in_progress_out));
		chk("gpp_out", 64'(GPP_INIT_MASK), 64'(general_purpose_port_out));
		for (i = 0; i < 70000 && u_init_rom_model.ptr !== 8'h19; i++)
			@(negedge clk);
		timeout(70000, "rom pointer");
		// Buffer full: link must hold the clock low, losing nothing
		k = 0;
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			k += int'(scl !== 1'b0);
		end
		chk("scl stall", 64'(0), 64'(k));
		chk("cpu_reset_n_out", 64'(0), 64'(cpu_reset_n_out));
		chk("wr_valid", 64'(1), 64'(wr_valid));
		@(posedge clk);
		wr_ready <= 1'b1;
		for (k = 0; k < 3; k++) begin
			@(negedge clk);
			for (i = 0; i < 8 && wr_valid !== 1'b1; i++)
				@(negedge clk);
			timeout(8, "wr_valid");
			chk("wr_rec", recs[k], 64'(wr_rec));
			@(posedge clk);
		end
		k = 0;
		for (i = 0; i < 25000 && cpu_reset_n_out !== 1'b1; i++) begin
			@(negedge clk);
			k += int'(wr_valid === 1'b1);
		end
		timeout(25000, "cpu_reset_n_out");
		chk("extra records", 64'(0), 64'(k));
		chk("init", 64'(0), 64'(init_in_progress_out));
		chk("nack_error", 64'(0), 64'(nack_error));
		// Straps point at an address where nobody answers
		start(32'h0000_0009);
		for (i = 0; i < 5000 && cpu_reset_n_out !== 1'b1; i++)
			@(negedge clk);
		timeout(5000, "cpu_reset_n_out");
		chk("nack_error", 64'(1), 64'(nack_error));
		chk("wr_valid", 64'(0), 64'(wr_valid));
		results();
	end
endmodule : tb_top
